// file: hdl/rcc_core.v
// rcc_core.v: 8-bit risc core with prefetch, stack and vectored interrupts
`timescale 1ns/100ps
`include "rcc_regs.vh"
// Notes on behaviour
// - next word fetched while current executes
// - separate program and data buses
// - 32 eight-bit registers, single-cycle access
// - read two, compute, write back, one cycle
// - three pointer pairs; z also reads program
// - register, immediate and single-operand alu ops
// - arithmetic updates status flags
// - one-word and two-word instructions decoded
// - call and interrupt push return address
// - stack pointer readable, writable in i/o
// - global enable in status gates interrupts
// - lower vector wins among pending sources
// - 64 i/o locations at 0x20 to 0x5F
// - five data addressing modes, linear map
// - entry clears global enable, reti sets
// - stack pointer minus two, plus two
// - registers at data addresses 0 to 31
module rcc_core (
	input wire ref_clk, // core clock, 100 MHz
	input wire rstn, // asynchronous reset, active low
	output reg [15:0] pm_addr, // program word address
	input wire [15:0] pm_rdata, // program word, one cycle later
	output reg [15:0] dm_addr, // data sram byte address
	output reg [7:0] dm_wdata, // data sram write byte
	output reg dm_we, // data sram write strobe
	output reg dm_re, // data sram read strobe
	input wire [7:0] dm_rdata, // data sram byte, one cycle later
	output reg [5:0] io_addr, // peripheral i/o location
	output reg [7:0] io_wdata, // peripheral write byte
	output reg io_we, // peripheral write strobe
	output reg io_re, // peripheral read strobe
	input wire [7:0] io_rdata, // peripheral byte, one cycle later
	input wire [7:0] irq_req, // interrupt requests, level
	output wire [7:0] irq_ack // one-hot entry pulse
);
	// ----------------------------------------
	// states and load sources
	// ----------------------------------------
	localparam [2:0] ST_START = 3'h0;
	localparam [2:0] ST_EXEC = 3'h1;
	localparam [2:0] ST_WORD2 = 3'h2;
	localparam [2:0] ST_LOAD = 3'h3;
	localparam [2:0] ST_PUSH_HI = 3'h4;
	localparam [2:0] ST_POP_HI = 3'h5;
	localparam [2:0] ST_POP_LO = 3'h6;
	localparam [2:0] ST_LPM = 3'h7;
	localparam [1:0] SRC_HOLD = 2'h0;
	localparam [1:0] SRC_IO = 2'h1;
	localparam [1:0] SRC_DM = 2'h2;
	// ----------------------------------------
	// reset release through two flops
	// ----------------------------------------
	reg rst_meta_q;
	reg rst_n_q;
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end
	// ----------------------------------------
	// state and decode
	// ----------------------------------------
	reg [2:0] state_q, state_d; // sequencer
	reg [15:0] program_counter_q, program_counter_d; // address of word on pm_rdata
	reg [15:0] ir_q, ir_d; // held first word
	reg [7:0] status_q, status_d; // i t h s v n z c
	reg [15:0] stack_pointer_q, stack_pointer_d; // stack top
	reg [7:0] irq_en_q, irq_en_d; // per-source enables
	reg [7:0] tmp_q, tmp_d; // return address byte
	reg [1:0] ld_src_q, ld_src_d; // where load data comes from
	reg [7:0] ld_val_q, ld_val_d; // load data caught early
	reg [7:0] irq_ack_q, irq_ack_d; // entry pulse
	wire [15:0] inst = (state_q == ST_EXEC) ? pm_rdata : ir_q;
	wire [3:0] op = inst[15:12];
	wire [2:0] msub = inst[11:9];
	wire [1:0] mode = inst[1:0];
	wire imm_op = (op >= `OP_SUBI) && (op <= `OP_LDI);
	wire [7:0] kimm = {inst[11:8], inst[3:0]};
	wire [15:0] next_word = program_counter_q + 16'h0001;
	assign irq_ack = irq_ack_q;
	// ----------------------------------------
	// interrupt acceptance and priority
	// ----------------------------------------
	wire [7:0] irq_pend = irq_req & irq_en_q;
	wire irq_take = (state_q == ST_EXEC) && status_q[`STATUS_I] && (irq_pend != 8'h00);
	reg [2:0] irq_idx; // winning source
	integer i;
	always @* begin
		irq_idx = 3'h0;
		for (i = `IRQ_N - 1; i >= 0; i = i - 1) begin
			if (irq_pend[i]) begin
				irq_idx = i[2:0];
			end
		end
	end
	// ----------------------------------------
	// register file
	// ----------------------------------------
	wire [7:0] ra_data, rb_data;
	wire [15:0] ptr_data;
	reg mem_go, mem_wr, ptr_upd;
	reg [15:0] mem_ea, ptr_new;
	reg w8_en;
	reg [4:0] w8_addr;
	reg [7:0] w8_data;
	wire [4:0] ra_addr = imm_op ? {1'b1, inst[7:4]} : inst[8:4];
	wire [1:0] ptr_sel = (op == `OP_MEM && msub == `MEM_LPM) ? `PTR_Z : inst[3:2];
	rcc_regfile u_rf (
		.clk(ref_clk),
		.rst_n(rst_n_q),
		.ra_addr(ra_addr),
		.ra_data(ra_data),
		.rb_addr(mem_go ? mem_ea[4:0] : {inst[9], inst[3:0]}),
		.rb_data(rb_data),
		.ptr_sel(ptr_sel),
		.ptr_data(ptr_data),
		.w8_en(w8_en),
		.w8_addr(w8_addr),
		.w8_data(w8_data),
		.w16_en(ptr_upd),
		.w16_sel(ptr_sel),
		.w16_data(ptr_new)
	);
	// ----------------------------------------
	// alu
	// ----------------------------------------
	wire [7:0] a = ra_data;
	wire [7:0] b = imm_op ? kimm : rb_data;
	wire cin = status_q[`STATUS_C] & (op == `OP_ADC || op == `OP_SBC);
	wire [8:0] add9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
	wire [8:0] sub9 = {1'b0, a} - {1'b0, b} - {8'h00, cin};
	wire [4:0] addh = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
	wire [4:0] subh = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
	reg [7:0] alu_r;
	reg fc, fh, fv, alu_fu;
	always @* begin
		alu_r = b;
		alu_fu = 1'b1;
		fc = status_q[0];
		fh = status_q[5];
		fv = 1'b0;
		case (op)
			`OP_ADD, `OP_ADC: begin
				alu_r = add9[7:0];
				fc = add9[8];
				fh = addh[4];
				fv = (a[7] == b[7]) && (alu_r[7] != a[7]);
			end
			`OP_SUB, `OP_SBC, `OP_SUBI: begin
				alu_r = sub9[7:0];
				fc = sub9[8];
				fh = subh[4];
				fv = (a[7] != b[7]) && (alu_r[7] != a[7]);
			end
			`OP_AND, `OP_ANDI: alu_r = a & b;
			`OP_OR, `OP_ORI: alu_r = a | b;
			`OP_EOR: alu_r = a ^ b;
			`OP_UNARY: begin
				case (inst[3:0])
					`UN_COM: begin
						alu_r = ~a;
						fc = 1'b1;
					end
					`UN_NEG: begin
						alu_r = 8'h00 - a;
						fc = (alu_r != 8'h00);
						fv = (alu_r == 8'h80);
						fh = alu_r[3] | a[3];
					end
					`UN_INC: begin
						alu_r = a + 8'h01;
						fv = (alu_r == 8'h80);
					end
					`UN_DEC: begin
						alu_r = a - 8'h01;
						fv = (alu_r == 8'h7F);
					end
					`UN_LSR: begin
						alu_r = {1'b0, a[7:1]};
						fc = a[0];
						fv = a[0];
					end
					`UN_ROR: begin
						alu_r = {status_q[0], a[7:1]};
						fc = a[0];
						fv = status_q[0] ^ a[0];
					end
					`UN_ASR: begin
						alu_r = {a[7], a[7:1]};
						fc = a[0];
						fv = a[7] ^ a[0];
					end
					default: begin
						alu_r = {a[3:0], a[7:4]};
						alu_fu = 1'b0;
					end
				endcase
			end
			default: alu_fu = 1'b0; // moves leave flags alone
		endcase
	end
	wire [5:0] alu_flags = {fh, alu_r[7] ^ fv, fv, alu_r[7], alu_r == 8'h00, fc};
	// ----------------------------------------
	// data access address generation
	// ----------------------------------------
	always @* begin
		mem_go = 1'b0;
		mem_wr = 1'b0;
		mem_ea = ptr_data;
		ptr_new = ptr_data;
		ptr_upd = 1'b0;
		if (state_q == ST_EXEC && !irq_take) begin
			if (op == `OP_IO) begin
				mem_go = 1'b1;
				mem_wr = inst[11];
				mem_ea = {10'h000, inst[10:9], inst[3:0]} + `DS_IO_BASE;
			end else if (op == `OP_MEM && msub[2:1] == 2'b00 && mode != `MODE_DISP) begin
				mem_go = 1'b1;
				mem_wr = msub[0];
				ptr_upd = (mode != `MODE_PLAIN);
				if (mode == `MODE_PREDEC) begin
					ptr_new = ptr_data - 16'h0001;
					mem_ea = ptr_new;
				end else if (mode == `MODE_POSTINC) begin
					ptr_new = ptr_data + 16'h0001;
				end
			end
		end else if (state_q == ST_WORD2 && op == `OP_MEM && msub[2] == 1'b0) begin
			mem_go = 1'b1;
			mem_wr = msub[0];
			mem_ea = msub[1] ? pm_rdata : ptr_data + pm_rdata;
		end
	end
	wire [15:0] io_off = mem_ea - `DS_IO_BASE;
	reg [7:0] io_int_val;
	reg io_int;
	always @* begin
		io_int = 1'b1;
		case (io_off[5:0])
			`IO_STATUS: io_int_val = status_q;
			`IO_STACK_HI: io_int_val = stack_pointer_q[15:8];
			`IO_STACK_LO: io_int_val = stack_pointer_q[7:0];
			`IO_IRQ_EN: io_int_val = irq_en_q;
			default: begin
				io_int_val = 8'h00;
				io_int = 1'b0;
			end
		endcase
	end
	// ----------------------------------------
	// sequencer and memory requests
	// ----------------------------------------
	always @* begin
		state_d = state_q;
		program_counter_d = program_counter_q;
		ir_d = ir_q;
		status_d = status_q;
		stack_pointer_d = stack_pointer_q;
		irq_en_d = irq_en_q;
		tmp_d = tmp_q;
		ld_src_d = ld_src_q;
		ld_val_d = ld_val_q;
		irq_ack_d = 8'h00;
		w8_en = 1'b0;
		w8_addr = ra_addr;
		w8_data = alu_r;
		dm_addr = stack_pointer_q;
		dm_wdata = tmp_q;
		dm_we = 1'b0;
		dm_re = 1'b0;
		io_addr = io_off[5:0];
		io_wdata = ra_data;
		io_we = 1'b0;
		io_re = 1'b0;
		pm_addr = 16'h0000;
		case (state_q)
			ST_START: state_d = ST_EXEC;
			ST_EXEC: begin
				ir_d = pm_rdata;
				program_counter_d = next_word;
				if (irq_take) begin
					program_counter_d = {13'h0000, irq_idx} + 16'h0001;
					status_d[`STATUS_I] = 1'b0;
					irq_ack_d[irq_idx] = 1'b1;
					dm_we = 1'b1;
					dm_wdata = program_counter_q[7:0];
					tmp_d = program_counter_q[15:8];
					state_d = ST_PUSH_HI;
				end else begin
					case (op)
						`OP_MISC: begin
							if (inst[11:8] == `MISC_RET || inst[11:8] == `MISC_RETI) begin
								dm_re = 1'b1;
								dm_addr = stack_pointer_q + 16'h0001;
								state_d = ST_POP_HI;
							end else if (inst[11:8] == `MISC_SEI) begin
								status_d[`STATUS_I] = 1'b1;
							end else if (inst[11:8] == `MISC_CLI) begin
								status_d[`STATUS_I] = 1'b0;
							end
						end
						`OP_IO: state_d = ST_EXEC;
						`OP_MEM: begin
							case (msub)
								`MEM_BR: begin
									if (status_q[inst[2:0]] == inst[8]) begin
										program_counter_d = next_word + {{11{inst[7]}}, inst[7:3]};
									end
								end
								`MEM_RJMP: program_counter_d = next_word + {{7{inst[8]}}, inst[8:0]};
								`MEM_LPM: state_d = ST_LPM;
								default: begin
									if (msub[2:1] != 2'b00 || mode == `MODE_DISP) begin
										state_d = ST_WORD2;
									end
								end
							endcase
						end
						default: begin
							w8_en = 1'b1;
							if (alu_fu) begin
								status_d[5:0] = alu_flags;
							end
						end
					endcase
				end
			end
			ST_WORD2: begin
				program_counter_d = next_word;
				state_d = ST_EXEC;
				if (msub == `MEM_JMP) begin
					program_counter_d = pm_rdata;
					if (inst[0]) begin
						dm_we = 1'b1;
						dm_wdata = next_word[7:0];
						tmp_d = next_word[15:8];
						state_d = ST_PUSH_HI;
					end
				end
			end
			ST_LOAD: begin
				w8_en = 1'b1;
				w8_addr = ir_q[8:4];
				w8_data = (ld_src_q == SRC_IO) ? io_rdata : (ld_src_q == SRC_DM) ? dm_rdata : ld_val_q;
				state_d = ST_EXEC;
			end
			ST_PUSH_HI: begin
				dm_we = 1'b1;
				dm_addr = stack_pointer_q - 16'h0001;
				stack_pointer_d = stack_pointer_q - 16'h0002;
				state_d = ST_EXEC;
			end
			ST_POP_HI: begin
				tmp_d = dm_rdata;
				dm_re = 1'b1;
				dm_addr = stack_pointer_q + 16'h0002;
				state_d = ST_POP_LO;
			end
			ST_POP_LO: begin
				program_counter_d = {tmp_q, dm_rdata};
				stack_pointer_d = stack_pointer_q + 16'h0002;
				if (ir_q[11:8] == `MISC_RETI) begin
					status_d[`STATUS_I] = 1'b1;
				end
				state_d = ST_EXEC;
			end
			default: begin
				w8_en = 1'b1;
				w8_addr = ir_q[8:4];
				w8_data = ptr_data[0] ? pm_rdata[15:8] : pm_rdata[7:0];
				state_d = ST_EXEC;
			end
		endcase
		if (mem_go) begin
			if (!mem_wr) begin
				state_d = ST_LOAD;
			end
			ld_src_d = SRC_HOLD;
			if (mem_ea < `DS_IO_BASE) begin
				w8_en = mem_wr;
				w8_addr = mem_ea[4:0];
				w8_data = ra_data;
				ld_val_d = rb_data;
			end else if (mem_ea < `DS_SRAM_BASE && io_int) begin
				ld_val_d = io_int_val;
				if (mem_wr && io_off[5:0] == `IO_STATUS) begin
					status_d = ra_data;
				end
				if (mem_wr && io_off[5:0] == `IO_STACK_HI) begin
					stack_pointer_d[15:8] = ra_data;
				end
				if (mem_wr && io_off[5:0] == `IO_STACK_LO) begin
					stack_pointer_d[7:0] = ra_data;
				end
				if (mem_wr && io_off[5:0] == `IO_IRQ_EN) begin
					irq_en_d = ra_data;
				end
			end else if (mem_ea < `DS_SRAM_BASE) begin
				io_we = mem_wr;
				io_re = !mem_wr;
				ld_src_d = SRC_IO;
			end else begin
				dm_addr = mem_ea;
				dm_wdata = ra_data;
				dm_we = mem_wr;
				dm_re = !mem_wr;
				ld_src_d = SRC_DM;
			end
		end
		pm_addr = (state_q == ST_EXEC && !irq_take && op == `OP_MEM && msub == `MEM_LPM) ?
			{1'b0, ptr_data[15:1]} : program_counter_d;
	end
	// ----------------------------------------
	// state registers
	// ----------------------------------------
	always @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q <= ST_START;
			program_counter_q <= 16'h0000;
			ir_q <= 16'h0000;
			status_q <= 8'h00;
			stack_pointer_q <= `STACK_RESET;
			irq_en_q <= 8'h00;
			tmp_q <= 8'h00;
			ld_src_q <= SRC_HOLD;
			ld_val_q <= 8'h00;
			irq_ack_q <= 8'h00;
		end else begin
			state_q <= state_d;
			program_counter_q <= program_counter_d;
			ir_q <= ir_d;
			status_q <= status_d;
			stack_pointer_q <= stack_pointer_d;
			irq_en_q <= irq_en_d;
			tmp_q <= tmp_d;
			ld_src_q <= ld_src_d;
			ld_val_q <= ld_val_d;
			irq_ack_q <= irq_ack_d;
		end
	end
endmodule

// file: hdl/rcc_regfile.v
// rcc_regfile.v: 32 x 8 working registers with a pointer pair port
`timescale 1ns/100ps
`include "rcc_regs.vh"
module rcc_regfile (
	input wire clk, // core clock
	input wire rst_n, // synchronised reset, active low
	input wire [4:0] ra_addr, // operand a select
	output wire [7:0] ra_data, // operand a value
	input wire [4:0] rb_addr, // operand b select
	output wire [7:0] rb_data, // operand b value
	input wire [1:0] ptr_sel, // pointer pair select
	output wire [15:0] ptr_data, // pointer pair value
	input wire w8_en, // byte write strobe
	input wire [4:0] w8_addr, // byte write select
	input wire [7:0] w8_data, // byte write value
	input wire w16_en, // pair write strobe
	input wire [1:0] w16_sel, // pair write select
	input wire [15:0] w16_data // pair write value
);
	reg [7:0] rf_q [0:31]; // register array
	wire [4:0] rd_base = `PAIR_BASE + {2'b00, ptr_sel, 1'b0}; // low half of read pair
	wire [4:0] wr_base = `PAIR_BASE + {2'b00, w16_sel, 1'b0}; // low half of write pair
	// ----------------------------------------
	// asynchronous read ports
	// ----------------------------------------
	assign ra_data = rf_q[ra_addr];
	assign rb_data = rf_q[rb_addr];
	assign ptr_data = {rf_q[rd_base + 5'h01], rf_q[rd_base]};
	// ----------------------------------------
	// one write process per entry, pair port wins
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 32; gi = gi + 1) begin : g_reg
			localparam [4:0] IDX = gi;
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					rf_q[IDX] <= 8'h00;
				end else if (w16_en && wr_base == IDX) begin
					rf_q[IDX] <= w16_data[7:0];
				end else if (w16_en && wr_base + 5'h01 == IDX) begin
					rf_q[IDX] <= w16_data[15:8];
				end else if (w8_en && w8_addr == IDX) begin
					rf_q[IDX] <= w8_data;
				end
			end
		end
	endgenerate
endmodule

// file: hdl/rcc_regs.vh
// rcc_regs.vh: encodings, addresses and reset values of the rcc processor core
`ifndef RCC_REGS_VH
`define RCC_REGS_VH
// ----------------------------------------
// major opcodes, word bits [15:12]
// ----------------------------------------
`define OP_MISC 4'h0
`define OP_UNARY 4'h1
`define OP_ADD 4'h2
`define OP_ADC 4'h3
`define OP_SUB 4'h4
`define OP_SBC 4'h5
`define OP_AND 4'h6
`define OP_OR 4'h7
`define OP_EOR 4'h8
`define OP_MOV 4'h9
`define OP_SUBI 4'hA
`define OP_ANDI 4'hB
`define OP_ORI 4'hC
`define OP_LDI 4'hD
`define OP_IO 4'hE
`define OP_MEM 4'hF
// ----------------------------------------
// sub codes
// ----------------------------------------
`define MISC_RET 4'h1
`define MISC_RETI 4'h2
`define MISC_SEI 4'h3
`define MISC_CLI 4'h4
`define MEM_LD 3'h0
`define MEM_ST 3'h1
`define MEM_LDS 3'h2
`define MEM_STS 3'h3
`define MEM_BR 3'h4
`define MEM_RJMP 3'h5
`define MEM_JMP 3'h6
`define MEM_LPM 3'h7
`define MODE_PLAIN 2'h0
`define MODE_POSTINC 2'h1
`define MODE_PREDEC 2'h2
`define MODE_DISP 2'h3
`define UN_COM 4'h0
`define UN_NEG 4'h1
`define UN_INC 4'h2
`define UN_DEC 4'h3
`define UN_LSR 4'h4
`define UN_ROR 4'h5
`define UN_ASR 4'h6
`define UN_SWAP 4'h7
// ----------------------------------------
// data space map and core i/o locations
// ----------------------------------------
`define DS_IO_BASE 16'h0020
`define DS_SRAM_BASE 16'h0060
`define IO_STATUS 6'h3F
`define IO_STACK_HI 6'h3E
`define IO_STACK_LO 6'h3D
`define IO_IRQ_EN 6'h3B
`define STACK_RESET 16'h00FF
`define STATUS_I 3'h7
`define STATUS_C 3'h0
`define IRQ_N 8
`define PTR_Z 2'h2
`define PAIR_BASE 5'h1A
`endif

// file: sim/rcc_core_properties.sv
// rcc_core_properties.sv: port-level assertions for the rcc core
`timescale 1ns/100ps
`include "rcc_regs.vh"
module rcc_core_properties (
	input wire ref_clk, // core clock
	input wire rstn, // reset, active low
	input wire [15:0] pm_addr, // program word address
	input wire [15:0] dm_addr, // data byte address
	input wire dm_we, // data write strobe
	input wire dm_re, // data read strobe
	input wire [5:0] io_addr, // i/o location
	input wire io_we, // i/o write strobe
	input wire [7:0] irq_req, // request levels
	input wire [7:0] irq_ack // entry pulse
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	property p_ack_onehot;
		(irq_ack != 8'h00) |-> $onehot(irq_ack);
	endproperty
	a_ack_onehot: assert property (p_ack_onehot) else $error("ack not one-hot");
	property p_ack_pulse;
		(irq_ack != 8'h00) |=> (irq_ack == 8'h00);
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_ack_requested;
		(irq_ack != 8'h00) |-> (($past(irq_req) & irq_ack) == irq_ack);
	endproperty
	a_ack_requested: assert property (p_ack_requested) else $error("ack without request");
	property p_ack_vector;
		(irq_ack != 8'h00) |-> (irq_ack == (8'h01 << ($past(pm_addr) - 16'h0001)));
	endproperty
	a_ack_vector: assert property (p_ack_vector) else $error("entry fetched wrong vector");
	property p_ack_push;
		(irq_ack != 8'h00) |-> dm_we && $past(dm_we) && (dm_addr == $past(dm_addr) - 16'h0001);
	endproperty
	a_ack_push: assert property (p_ack_push) else $error("return address not pushed");
	property p_one_access;
		!(dm_we && dm_re);
	endproperty
	a_one_access: assert property (p_one_access) else $error("read and write together");
	property p_io_core_local;
		io_we |-> !(io_addr inside {`IO_STATUS, `IO_STACK_HI, `IO_STACK_LO, `IO_IRQ_EN});
	endproperty
	a_io_core_local: assert property (p_io_core_local) else $error("core register leaked");
	property p_dm_above_io;
		(dm_we || dm_re) |-> (dm_addr >= `DS_SRAM_BASE);
	endproperty
	a_dm_above_io: assert property (p_dm_above_io) else $error("low address sent to sram");
	// ----------------------------------------
	// covers
	// ----------------------------------------
	c_ack: cover property (irq_ack != 8'h00);
	c_io_write: cover property (io_we);
	c_push_pair: cover property (dm_we ##1 dm_we);
endmodule

// file: sim/rcc_core_test.sv
// rcc_core_test.sv: self-checking bench running small programs on the core
`timescale 1ns/100ps
`include "rcc_regs.vh"
module rcc_core_test;
	reg ref_clk; // core clock
	reg rstn; // reset, active low
	reg [7:0] irq_req; // request levels
	wire [15:0] pm_addr, pm_rdata, dm_addr;
	wire [7:0] dm_wdata, dm_rdata, io_wdata, io_rdata, irq_ack;
	wire [5:0] io_addr;
	wire dm_we, dm_re, io_we, io_re;
	integer bad_count, n_tests, pc_w, n_acks;
	reg [7:0] ack_log [0:3]; // acknowledges in arrival order
	reg [7:0] ack_mark; // gate marker seen at first entry
	rcc_core rcc_core_inst (.ref_clk(ref_clk), .rstn(rstn), .pm_addr(pm_addr),
		.pm_rdata(pm_rdata), .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_we(dm_we),
		.dm_re(dm_re), .dm_rdata(dm_rdata), .io_addr(io_addr), .io_wdata(io_wdata),
		.io_we(io_we), .io_re(io_re), .io_rdata(io_rdata), .irq_req(irq_req),
		.irq_ack(irq_ack));
	rcc_mem_model rcc_mem_model_inst (.clk(ref_clk), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
		.dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_we(dm_we), .dm_re(dm_re),
		.dm_rdata(dm_rdata), .io_addr(io_addr), .io_wdata(io_wdata), .io_we(io_we),
		.io_re(io_re), .io_rdata(io_rdata));
	// ----------------------------------------
	// clock, watchdog, acknowledge monitor
	// ----------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// three runs of 3000 cycles at most
	initial begin
		#200000;
		bad_count = bad_count + 1;
		report_and_stop;
	end
	// log each entry and drop the served request
	always @(negedge ref_clk) begin
		if (|irq_ack === 1'b1) begin
			if (n_acks == 0) begin
				ack_mark = dm(8'h87);
			end
			if (n_acks < 4) begin
				ack_log[n_acks] = irq_ack;
			end
			n_acks = n_acks + 1;
			irq_req <= irq_req & ~irq_ack;
		end
	end
	// ----------------------------------------
	// encoders and common tasks
	// ----------------------------------------
	function [15:0] f_imm(input [3:0] op, input [4:0] d, input [7:0] k);
		f_imm = {op, k[7:4], d[3:0], k[3:0]};
	endfunction
	function [15:0] f_io(input wr, input [4:0] r, input [5:0] a);
		f_io = {`OP_IO, wr, a[5:4], r, a[3:0]};
	endfunction
	function [15:0] f_alu(input [3:0] op, input [4:0] d, input [4:0] r);
		f_alu = {op, 2'b00, r[4], d, r[3:0]};
	endfunction
	function [15:0] f_mem(input [2:0] sub, input [4:0] r, input [3:0] lo);
		f_mem = {`OP_MEM, sub, r, lo};
	endfunction
	// data sram byte
	function [7:0] dm(input [7:0] a);
		dm = rcc_mem_model_inst.dmem[a];
	endfunction
	task check(input [7:0] seen, input [7:0] expect_v);
		begin
			n_tests = n_tests + 1;
			if (seen !== expect_v) begin
				bad_count = bad_count + 1;
				$display("ERROR t=%0t seen=%h expected=%h", $time, seen, expect_v);
			end
		end
	endtask
	task emit(input [15:0] w);
		begin
			rcc_mem_model_inst.pmem[pc_w] = w;
			pc_w = pc_w + 1;
		end
	endtask
	task sts(input [4:0] r, input [15:0] a);
		begin
			emit(f_mem(`MEM_STS, r, 4'h0));
			emit(a);
		end
	endtask
	task ldi(input [4:0] d, input [7:0] k);
		emit(f_imm(`OP_LDI, d, k));
	endtask
	// jump, or call when call is set
	task jmp(input call, input [15:0] t);
		begin
			emit(f_mem(`MEM_JMP, 5'd0, {3'h0, call}));
			emit(t);
		end
	endtask
	task clear_mems;
		integer i;
		begin
			for (i = 0; i < 256; i = i + 1) begin
				rcc_mem_model_inst.pmem[i] = 16'h0000;
				rcc_mem_model_inst.dmem[i] = 8'hAA;
				rcc_mem_model_inst.iomem[i[5:0]] = 8'h00;
			end
			pc_w = 0;
			n_acks = 0;
		end
	endtask
	// software loads the stack pointer before any call or interrupt
	task set_stack;
		begin
			ldi(5'd16, 8'h00);
			emit(f_io(1'b1, 5'd16, `IO_STACK_HI));
			ldi(5'd16, 8'hF0);
			emit(f_io(1'b1, 5'd16, `IO_STACK_LO));
		end
	endtask
	// writes the done marker, then spins on itself
	task finish_prog;
		integer t;
		begin
			ldi(5'd24, 8'h5A);
			sts(5'd24, 16'h00FE);
			t = pc_w;
			jmp(1'b0, t[15:0]);
		end
	endtask
	// reset for four cycles, then wait for the done marker
	task run_prog;
		integer k;
		begin
			@(negedge ref_clk);
			rstn = 1'b0;
			repeat (4) @(negedge ref_clk);
			rstn = 1'b1;
			k = 0;
			while (dm(8'hFE) !== 8'h5A && k < 3000) begin
				@(negedge ref_clk);
				k = k + 1;
			end
			check(dm(8'hFE), 8'h5A);
		end
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	// alu, flags, immediates, register and i/o mapping, pointer modes
	task t_alu_map;
		begin
			clear_mems;
			ldi(5'd16, 8'hFF);
			ldi(5'd17, 8'h01);
			emit(f_alu(`OP_ADD, 5'd16, 5'd17));
			emit(f_io(1'b0, 5'd18, `IO_STATUS));
			sts(5'd18, 16'h0080);
			ldi(5'd16, 8'h35);
			ldi(5'd17, 8'h4A);
			emit(f_alu(`OP_ADD, 5'd16, 5'd17));
			sts(5'd16, 16'h0081);
			sts(5'd16, 16'h0003);
			sts(5'd3, 16'h0082);
			ldi(5'd26, 8'h83);
			ldi(5'd27, 8'h00);
			emit(f_mem(`MEM_ST, 5'd17, {2'h0, `MODE_POSTINC}));
			emit(f_mem(`MEM_ST, 5'd16, {2'h0, `MODE_PLAIN}));
			emit(f_io(1'b1, 5'd16, 6'h05));
			sts(5'd17, 16'h0026);
			emit(f_mem(`MEM_LDS, 5'd21, 4'h0));
			emit(16'h0025);
			emit(f_mem(`MEM_LD, 5'd20, {2'h0, `MODE_PREDEC}));
			sts(5'd21, 16'h008C);
			sts(5'd20, 16'h008D);
			ldi(5'd19, 8'h3C);
			emit(f_imm(`OP_ANDI, 5'd19, 8'h0F));
			emit({`OP_UNARY, 3'b000, 5'd19, `UN_INC});
			emit(f_imm(`OP_SUBI, 5'd19, 8'h03));
			emit(f_imm(`OP_ORI, 5'd19, 8'h50));
			sts(5'd19, 16'h008B);
			finish_prog;
			run_prog;
			check(dm(8'h80) & 8'h07, 8'h03);
			check(dm(8'h81), 8'h7F);
			check(dm(8'h82), 8'h7F);
			check(dm(8'h83), 8'h4A);
			check(dm(8'h84), 8'h7F);
			check(rcc_mem_model_inst.iomem[5], 8'h7F);
			check(rcc_mem_model_inst.iomem[6], 8'h4A);
			check(dm(8'h8C), 8'h7F);
			check(dm(8'h8D), 8'h4A);
			check(dm(8'h8B), 8'h5A);
		end
	endtask
	// call pushes the return word, return pops it
	task t_call_ret;
		begin
			clear_mems;
			set_stack;
			jmp(1'b1, 16'd40);
			emit(f_io(1'b0, 5'd18, `IO_STACK_LO));
			sts(5'd18, 16'h0085);
			finish_prog;
			pc_w = 40;
			emit(f_io(1'b0, 5'd19, `IO_STACK_LO));
			sts(5'd19, 16'h0086);
			emit({`OP_MISC, `MISC_RET, 8'h00});
			run_prog;
			check(dm(8'hF0), 8'h06);
			check(dm(8'hEF), 8'h00);
			check(dm(8'h86), 8'hEE);
			check(dm(8'h85), 8'hF0);
		end
	endtask
	// 0 and 6 pend unenabled; 5 beats 7; i bit gates entry
	task t_irq;
		begin
			clear_mems;
			jmp(1'b0, 16'd16);
			pc_w = 6;
			jmp(1'b0, 16'd40);
			jmp(1'b0, 16'd50);
			pc_w = 16;
			set_stack;
			ldi(5'd16, 8'hA0);
			emit(f_io(1'b1, 5'd16, `IO_IRQ_EN));
			ldi(5'd16, 8'h3C);
			sts(5'd16, 16'h0087);
			emit({`OP_MISC, `MISC_SEI, 8'h00});
			ldi(5'd22, 8'h00);
			emit(f_io(1'b0, 5'd21, `IO_STATUS));
			sts(5'd21, 16'h008A);
			finish_prog;
			pc_w = 40;
			emit(f_io(1'b0, 5'd20, `IO_STATUS));
			sts(5'd20, 16'h0088);
			emit({`OP_MISC, `MISC_RETI, 8'h00});
			pc_w = 50;
			emit(f_io(1'b0, 5'd20, `IO_STATUS));
			sts(5'd20, 16'h0089);
			emit({`OP_MISC, `MISC_RETI, 8'h00});
			irq_req = 8'hE1;
			run_prog;
			check(n_acks[7:0], 8'h02);
			check(ack_log[0], 8'h20);
			check(ack_log[1], 8'h80);
			check(ack_mark, 8'h3C);
			check(dm(8'h88) & 8'h80, 8'h00);
			check(dm(8'h89) & 8'h80, 8'h00);
			check(dm(8'h8A) & 8'h80, 8'h80);
			@(negedge ref_clk);
			irq_req = 8'h00;
		end
	endtask
	// ----------------------------------------
	// verdict and main sequence
	// ----------------------------------------
	task report_and_stop;
		begin
			if (bad_count == 0 && n_tests > 0) begin
				$display("RESULT: PASS");
			end else begin
				$display("RESULT: FAIL");
			end
			$finish;
		end
	endtask
	initial begin
		rstn = 1'b0;
		irq_req = 8'h00;
		bad_count = 0;
		n_tests = 0;
		repeat (4) @(negedge ref_clk);
		t_alu_map;
		t_call_ret;
		t_irq;
		report_and_stop;
	end
endmodule
bind rcc_core rcc_core_properties rcc_core_properties_inst (.ref_clk(ref_clk), .rstn(rstn),
	.pm_addr(pm_addr), .dm_addr(dm_addr), .dm_we(dm_we), .dm_re(dm_re),
	.io_addr(io_addr), .io_we(io_we), .irq_req(irq_req), .irq_ack(irq_ack));

// file: sim/rcc_mem_model.sv
// rcc_mem_model.sv: program, data and i/o memories facing the core
`timescale 1ns/100ps
module rcc_mem_model (
	input wire clk, // core clock
	input wire [15:0] pm_addr, // program word address
	output reg [15:0] pm_rdata, // program word, next cycle
	input wire [15:0] dm_addr, // data byte address
	input wire [7:0] dm_wdata, // data write byte
	input wire dm_we, // data write strobe
	input wire dm_re, // data read strobe
	output reg [7:0] dm_rdata, // data byte, next cycle
	input wire [5:0] io_addr, // i/o location
	input wire [7:0] io_wdata, // i/o write byte
	input wire io_we, // i/o write strobe
	input wire io_re, // i/o read strobe
	output reg [7:0] io_rdata // i/o byte, next cycle
);
	reg [15:0] pmem [0:255]; // program store, loaded by the bench
	reg [7:0] dmem [0:255]; // data sram
	reg [7:0] iomem [0:63]; // peripheral locations
	initial begin
		pm_rdata = 16'h0000;
		dm_rdata = 8'h00;
		io_rdata = 8'h00;
	end
	// program bus answers every cycle, own port
	always @(posedge clk) begin
		pm_rdata <= pmem[pm_addr[7:0]];
	end
	// data bus: idle read data toggles so stale bytes never look valid
	always @(posedge clk) begin
		if (dm_we) begin
			dmem[dm_addr[7:0]] <= dm_wdata;
		end
		if (dm_re) begin
			dm_rdata <= dmem[dm_addr[7:0]];
		end else begin
			dm_rdata <= ~dm_rdata;
		end
	end
	// i/o bus, same scheme
	always @(posedge clk) begin
		if (io_we) begin
			iomem[io_addr] <= io_wdata;
		end
		if (io_re) begin
			io_rdata <= iomem[io_addr];
		end else begin
			io_rdata <= ~io_rdata;
		end
	end
endmodule
